// [phy_diag_map.vh]
`ifndef PHY_DIAG_MAP_VH
`define PHY_DIAG_MAP_VH

// Register addresses (5-bit management register numbers)
`define ADDR_CABLE_DIAGNOSTIC   5'h12
`define ADDR_DIGITAL_LINK       5'h13
`define ADDR_SYMBOL_ERR_COUNT   5'h15
`define ADDR_INT_CTRL_STATUS    5'h1b

// Cable diagnostic fields
`define DIAG_TEST_ENABLE_BIT    15
`define DIAG_RSVD14_BIT         14
`define DIAG_PAIR_HI            13
`define DIAG_PAIR_LO            12
`define DIAG_RSVD_HI            11
`define DIAG_RSVD_LO            10
`define DIAG_STATUS_HI          9
`define DIAG_STATUS_LO          8
`define DIAG_DIST_HI            7
`define DIAG_DIST_LO            0

`define DIAG_PAIR_RESET         2'h0
`define DIAG_STATUS_RESET       2'h0
`define DIAG_DIST_RESET         8'h00
`define DIAG_RSVD_RESET         2'h0
`define DIAG_RSVD14_RESET       1'h0

// Digital link status fields
`define LINK_1000_BIT           2
`define LINK_100_BIT            1
`define LINK_RESET              2'h0

// Symbol error counter
`define SYMBOL_ERR_RESET        16'h0000
`define SYMBOL_ERR_MAX          16'hffff

// Interrupt control/status fields
`define INT_EN_HI               15
`define INT_EN_LO               8
`define INT_FLAG_HI             7
`define INT_FLAG_LO             0
`define INT_EN_RESET            8'h00
`define INT_FLAG_RESET          8'h00

`endif

// [phy_diag_status_int_regs.v]
// Function
// - A read/write two-bit pair select in the diagnostic register picks pair A to D and resets to 00.
// - A read-only two-bit result reports normal, open or short for the selected pair and resets to 00.
// - A read-only eight-bit low byte gives the distance to a reported fault and resets to zero.
// - Link status bit 2 shows a good 1000BASE-T link and bit 1 a good 100BASE-TX link, both reset to 0.
// - A 16-bit symbol error frame counter clears when read and resets to zero.
// - Interrupt bits 15 to 10 enable jabber, receive error, page, parallel fault, partner ack and link down.
// - Writing 1 to the test enable bit starts the cable test and the device clears it when the test ends.
// - The low eight interrupt bits are event flags that set on events and clear when the register is read.
`timescale 1ns/10ps
`default_nettype none
`include "phy_diag_map.vh"

module phy_diag_status_int_regs (
  input  wire        mclk,
  input  wire        rstn,
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output wire        diag_start,
  output wire [1:0]  diag_pair,
  input  wire        diag_done,
  input  wire [1:0]  diag_result,
  input  wire [7:0]  diag_distance,
  input  wire        link_ok_1000,
  input  wire        link_ok_100,
  input  wire        symbol_error_frame,
  input  wire [7:0]  int_events,
  output wire        int_out
);

  // One-hot states of the cable test sequencer
  localparam DIAG_IDLE = 2'b01;
  localparam DIAG_RUN  = 2'b10;

  reg [1:0]  diag_state_q;
  reg [1:0]  diag_state_d;
  reg [1:0]  pair_q;
  reg [1:0]  rsvd_q;
  reg        rsvd14_q;
  reg [1:0]  status_q;
  reg [7:0]  distance_q;
  reg [1:0]  link_q;
  reg [15:0] symbol_error_frame_count_q;
  reg [15:0] symbol_error_frame_count_d;
  reg [7:0]  int_en_q;
  reg [7:0]  int_flag_q;
  reg [7:0]  int_flag_d;
  reg [15:0] reg_rdata_d;

  wire [3:0] reg_sel;
  wire       test_busy;
  wire       wr_diag;
  wire       rd_cnt;
  wire       wr_int;
  wire       rd_int;
  wire       diag_finish;

  // One-hot select: bit 0 diagnostic, 1 link, 2 counter, 3 interrupt; none for unmapped
  function [3:0] reg_select;
    input [4:0] addr;
    begin
      if (addr == `ADDR_CABLE_DIAGNOSTIC)
        reg_select = 4'h1;
      else if (addr == `ADDR_DIGITAL_LINK)
        reg_select = 4'h2;
      else if (addr == `ADDR_SYMBOL_ERR_COUNT)
        reg_select = 4'h4;
      else if (addr == `ADDR_INT_CTRL_STATUS)
        reg_select = 4'h8;
      else
        reg_select = 4'h0;
    end
  endfunction

  assign reg_sel = reg_select(reg_addr);
  assign wr_diag = reg_wr && reg_sel[0];
  assign rd_cnt  = reg_rd && reg_sel[2];
  assign wr_int  = reg_wr && reg_sel[3];
  assign rd_int  = reg_rd && reg_sel[3];

  assign test_busy   = diag_state_q[1];
  // Done is ignored while idle, so a stray pulse cannot load stale results
  assign diag_finish = test_busy && diag_done;
  // Start pulse only when idle; a rewrite during a test does not restart it
  assign diag_start  = wr_diag && reg_wdata[`DIAG_TEST_ENABLE_BIT] && !test_busy;
  assign diag_pair   = pair_q;

  always @*
  begin
    diag_state_d = diag_state_q;
    case (diag_state_q)
      DIAG_IDLE:
        if (diag_start)
          diag_state_d = DIAG_RUN;
      DIAG_RUN:
        if (diag_done)
          diag_state_d = DIAG_IDLE;
      default:
        diag_state_d = DIAG_IDLE;
    endcase
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      diag_state_q <= DIAG_IDLE;
    else
      diag_state_q <= diag_state_d;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      pair_q   <= `DIAG_PAIR_RESET;
      rsvd_q   <= `DIAG_RSVD_RESET;
      rsvd14_q <= `DIAG_RSVD14_RESET;
    end
    else if (wr_diag)
    begin
      pair_q   <= reg_wdata[`DIAG_PAIR_HI:`DIAG_PAIR_LO];
      rsvd_q   <= reg_wdata[`DIAG_RSVD_HI:`DIAG_RSVD_LO];
      rsvd14_q <= reg_wdata[`DIAG_RSVD14_BIT];
    end
  end

  // Loaded only on a finish, so a read during a test shows the last result
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      status_q   <= `DIAG_STATUS_RESET;
      distance_q <= `DIAG_DIST_RESET;
    end
    else if (diag_finish)
    begin
      status_q   <= diag_result;
      distance_q <= diag_distance;
    end
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      link_q <= `LINK_RESET;
    else
      link_q <= {link_ok_1000, link_ok_100};
  end

  // Counter saturates instead of wrapping; an event on the read cycle is kept
  always @*
  begin
    symbol_error_frame_count_d = symbol_error_frame_count_q;
    if (rd_cnt)
      symbol_error_frame_count_d = `SYMBOL_ERR_RESET;
    if (symbol_error_frame && (rd_cnt || symbol_error_frame_count_q != `SYMBOL_ERR_MAX))
      symbol_error_frame_count_d = symbol_error_frame_count_d + 16'h0001;
  end

  // Set wins over the clear-on-read
  always @*
  begin
    int_flag_d = rd_int ? `INT_FLAG_RESET : int_flag_q;
    int_flag_d = int_flag_d | int_events;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      symbol_error_frame_count_q <= `SYMBOL_ERR_RESET;
    else
      symbol_error_frame_count_q <= symbol_error_frame_count_d;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      int_en_q   <= `INT_EN_RESET;
      int_flag_q <= `INT_FLAG_RESET;
    end
    else
    begin
      int_flag_q <= int_flag_d;
      if (wr_int)
        int_en_q <= reg_wdata[`INT_EN_HI:`INT_EN_LO];
    end
  end

  // Enable bit 8+n gates flag n
  assign int_out = |(int_en_q & int_flag_q);

  // Read data only moves on a read, so it stands until the next one
  always @*
  begin
    reg_rdata_d = reg_rdata;
    if (reg_rd)
    begin
      if (reg_sel[0])
        reg_rdata_d = {test_busy, rsvd14_q, pair_q, rsvd_q, status_q, distance_q};
      else if (reg_sel[1])
        reg_rdata_d = {13'h0000, link_q, 1'h0};
      else if (reg_sel[2])
        reg_rdata_d = symbol_error_frame_count_q;
      else if (reg_sel[3])
        reg_rdata_d = {int_en_q, int_flag_q};
      else
        reg_rdata_d = 16'h0000;
    end
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rdata_d;
  end

endmodule // phy_diag_status_int_regs
`default_nettype wire

// [diag_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module diag_engine_model (
  input  wire logic       mclk,
  input  wire logic       diag_start,
  input  wire logic [3:0] dly,
  input  wire logic [1:0] res,
  output logic            diag_done,
  output logic [1:0]      diag_result,
  output logic [7:0]      diag_distance
);
  logic [3:0] cnt_q = 4'h0;
  // Lines are junk outside the done pulse, never a stale copy
  assign diag_result = diag_done ? res : ~res;
  assign diag_distance = diag_done ? 8'h54 | 8'(res) : ~(8'h54 | 8'(res));
  always @(posedge mclk)
  begin
    diag_done <= cnt_q == 4'h1;
    cnt_q <= diag_start ? dly : cnt_q - 4'(cnt_q != 4'h0);
  end
endmodule // diag_engine_model
`default_nettype wire

// [phy_diag_status_int_regs_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_diag_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        diag_start,
  input wire logic        symbol_error_frame,
  input wire logic        int_out,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0]  diag_pair,
  input wire logic [7:0]  int_events
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic w12 = reg_wr && reg_addr == 5'h12, wi = reg_wr && reg_addr == 5'h1b;
  wire logic ri = reg_rd && reg_addr == 5'h1b, rc = reg_rd && reg_addr == 5'h15 && !symbol_error_frame;
  a_pair_wr: assert property (w12 |=> diag_pair == $past(reg_wdata[13:12])) else $error("pair");
  a_start_src: assert property (diag_start |-> w12 && reg_wdata[15]) else $error("start");
  a_start_once: assert property (diag_start |=> !diag_start) else $error("restart");
  a_link_rsvd: assert property (reg_rd && reg_addr == 5'h13 |=> !reg_rdata[15:3]) else $error("link");
  a_cnt_clear: assert property (rc ##1 !symbol_error_frame ##1 rc |=> !reg_rdata) else $error("count");
  a_int_clear: assert property (ri && !int_events |=> !int_out) else $error("clear");
  a_int_raise: assert property (wi && reg_wdata[10] ##1 int_events[2] && !reg_wr && !reg_rd |=> int_out)
    else $error("raise");
  a_en_rw: assert property (wi ##1 !reg_wr ##1 ri |=> reg_rdata[15:8] == $past(reg_wdata[15:8], 3))
    else $error("enable");
  cover property (diag_start);
  cover property (w12 && reg_wdata[15] && !diag_start);
  cover property (int_out);
  cover property (rc);
endmodule // phy_diag_chk
bind phy_diag_status_int_regs phy_diag_chk u_chk (.*);
`default_nettype wire

// [phy_diag_status_int_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_diag_status_int_regs_tb;
  logic mclk=0, rstn=0, reg_wr=0, reg_rd=0, link_ok_1000=0, link_ok_100=0, symbol_error_frame=0;
  logic diag_done, diag_start, int_out;
  logic [1:0] diag_pair, diag_result, res=0;
  logic [3:0] dly=1;
  logic [4:0] reg_addr=0;
  logic [7:0] diag_distance, int_events=0;
  logic [15:0] reg_wdata=0, reg_rdata;
  int fail_count=0, tests_run=0, cyc=0, starts=0;
  phy_diag_status_int_regs u_dut (.*);
  diag_engine_model u_eng (.*);
  initial forever #12.5 mclk = ~mclk;
  task chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge mclk) #1 reg_wr = 0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk) #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge mclk) #1 reg_rd = 0;
    chk(reg_rdata, e);
  endtask
  task test_done;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    starts += diag_start;
    if (++cyc == 3000)
    begin
      fail_count++;
      test_done;
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 rstn = 1;
    // Third address is unmapped and must read zero
    for (int a = 0; a < 4; a++) rd(5'h12 + 5'(a), 16'h0000);
    // Prompt answer, then a slow one read back while still busy
    for (int i = 1; i < 3; i++)
    begin
      {dly, res} = {4'(i * 6 - 5), 2'(i)};
      wr(5'h12, 16'(i << 12) | 16'h8000);
      // Busy with the first result still standing; a restart must be refused
      if (i == 2)
      begin
        rd(5'h12, 16'ha155);
        wr(5'h12, 16'ha000);
      end
      repeat (10) @(posedge mclk);
      rd(5'h12, {4'(i), 2'b00, 2'(i), 8'h54 | 8'(i)});
      chk(16'(diag_pair), 16'(i));
    end
    chk(16'(starts), 16'h0002);
    $display("diag test done");
    symbol_error_frame = 1;
    repeat (3) @(posedge mclk);
    #1 symbol_error_frame = 0;
    rd(5'h15, 16'h0003);
    rd(5'h15, 16'h0000);
    {link_ok_1000, link_ok_100} = 2'b10;
    repeat (2) @(posedge mclk);
    rd(5'h13, 16'h0004);
    wr(5'h1b, 16'hfcff);
    int_events = 8'h04;
    @(posedge mclk) #1 int_events = 8'h00;
    chk(16'(int_out), 16'h0001);
    rd(5'h1b, 16'hfc04);
    chk(16'(int_out), 16'h0000);
    wr(5'h1b, 16'h0000);
    rd(5'h1b, 16'h0000);
    int_events = 8'h80;
    @(posedge mclk) #1 int_events = 8'h00;
    chk(16'(int_out), 16'h0000);
    rd(5'h1b, 16'h0080);
    $display("status test done");
    test_done;
  end
endmodule // phy_diag_status_int_regs_tb
`default_nettype wire
